// *** dfh_bus_if.sv ***
// Purpose: Device-side bus interface of a DDR serial NOR flash
// Assumes: Bus clock, strobe clock and select are sampled by core_clk
// Notes: Array, register overlays and ECC live outside this block
`timescale 1ns/1ps
module dfh_bus_if
  import dfh_pkg::*;
#(
  parameter logic [POR_CNT_W-1:0] POR_WAIT = POR_CYCLES[POR_CNT_W-1:0]
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Flash bus pins
  input wire logic cs_n_pin,
  input wire logic bus_clk_pin,
  input wire logic skew_clock,
  input wire logic skew_clock_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic rwds_out,
  output logic rwds_oe,
  // Sideband pins
  input wire logic hw_reset_n_pin,
  output logic int_out,
  output logic int_oe,
  output logic por_out_n,
  output logic por_oe,
  // Configuration
  input wire logic [7:0] latency_config_reg,
  input wire logic skew_clock_en,
  input wire logic [POR_CNT_W-1:0] por_timeout,
  input wire logic por_busy,
  input wire logic event_pending,
  // Decoded command/address
  output logic ca_valid,
  output logic ca_read,
  output logic ca_space,
  output logic ca_linear,
  output logic [HP_W-1:0] ca_half_page,
  output logic [WORD_W-1:0] ca_word,
  // Command buffer write
  output logic cmd_wr,
  output logic [HP_W-1:0] cmd_half_page,
  output logic [WORD_W-1:0] cmd_word,
  output logic [15:0] cmd_data,
  // Read data source
  input wire logic [15:0] rd_data,
  output logic rd_req,
  // Status
  output logic standby,
  output logic in_reset,
  output logic busy
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic cs_s;
  logic ck_s;
  logic psc_s;
  logic rst_pin_s;
  logic [3:0] sync_in;
  logic [3:0] sync_out;
  // Active-low pins enter inverted so reset state equals their idle level
  assign sync_in = {~hw_reset_n_pin, skew_clock & ~skew_clock_n,
                    bus_clk_pin, ~cs_n_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      dfh_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(sync_in[gi]),
        .sync_out(sync_out[gi])
      );
    end
  endgenerate
  assign cs_s = ~sync_out[0];
  assign ck_s = sync_out[1];
  assign psc_s = sync_out[2];
  assign rst_pin_s = ~sync_out[3];

  // ------------------------------------------------------------
  // Edge detection
  // ------------------------------------------------------------
  logic cs_d;
  logic ck_d;
  logic psc_d;
  logic dev_rst;
  assign dev_rst = ~rst_pin_s;
  wire cs_fall = cs_d & ~cs_s;
  wire cs_rise = ~cs_d & cs_s;
  wire ck_rise = ~ck_d & ck_s;
  wire ck_fall = ck_d & ~ck_s;
  wire psc_rise = ~psc_d & psc_s;
  wire psc_fall = psc_d & ~psc_s;
  wire ck_edge = ck_rise | ck_fall;
  // Strobe timebase: skew clock when enabled, bus clock otherwise
  wire strb_edge = skew_clock_en ? (psc_rise | psc_fall) : ck_edge;
  wire strb_rise = skew_clock_en ? psc_rise : ck_rise;

  // ------------------------------------------------------------
  // Transaction state
  // ------------------------------------------------------------
  dfh_state_e state;
  dfh_state_e next_state;
  logic [2:0] edge_cnt;
  logic [CA_W-1:0] ca_shift;
  logic [4:0] lat_cnt;
  logic [7:0] wr_hi;
  logic [15:0] rd_hold;
  logic rd_lo_phase;
  logic ca_done;
  logic [4:0] lat_clocks;
  logic [3:0] lat_code;
  assign lat_code = latency_config_reg[LAT_HI:LAT_LO];
  // Reserved codes clamp to the longest defined latency
  assign lat_clocks = (lat_code > LAT_MAX_CODE) ?
    5'(LAT_MAX_CODE) + 5'(LAT_BASE) : 5'(lat_code) + 5'(LAT_BASE);
  assign ca_done = (state == DFH_CA) && ck_edge &&
                   (edge_cnt == 3'(CA_EDGES - 1));
  wire [CA_W-1:0] ca_full = {ca_shift[CA_W-9:0], dq_in};
  wire lat_done = (lat_cnt == 5'h00);

  always_comb begin
    next_state = state;
    case (state)
      DFH_IDLE: begin
        if (cs_fall && !ck_s) begin
          next_state = DFH_CA;
        end
      end
      DFH_CA: begin
        if (ca_done) begin
          next_state = DFH_LAT;
        end
      end
      DFH_LAT: begin
        // Latency counts rising clocks; writes get no latency wait
        if (!ca_read) begin
          next_state = DFH_WDATA;
        end else if (lat_done) begin
          next_state = DFH_RDATA;
        end
      end
      DFH_RDATA: next_state = DFH_RDATA;
      DFH_WDATA: next_state = DFH_WDATA;
      DFH_DONE: next_state = DFH_DONE;
      default: next_state = DFH_IDLE;
    endcase
    if (state != DFH_IDLE && cs_rise) begin
      next_state = DFH_IDLE;
    end
    if (dev_rst) begin
      next_state = DFH_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= DFH_IDLE;
      cs_d <= 1'b1;
      ck_d <= 1'b0;
      psc_d <= 1'b0;
    end else begin
      state <= next_state;
      cs_d <= cs_s;
      ck_d <= ck_s;
      psc_d <= psc_s;
    end
  end

  // ------------------------------------------------------------
  // Command/address capture and field decode
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n || dev_rst || state == DFH_IDLE) begin
      edge_cnt <= 3'h0;
      ca_shift <= '0;
    end else if (state == DFH_CA && ck_edge) begin
      edge_cnt <= edge_cnt + 3'h1;
      ca_shift <= ca_full;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || dev_rst) begin
      ca_valid <= 1'b0;
      ca_read <= 1'b0;
      ca_space <= 1'b0;
      ca_linear <= 1'b0;
      ca_half_page <= '0;
      ca_word <= '0;
    end else begin
      ca_valid <= ca_done;
      if (ca_done) begin
        ca_read <= ca_full[CA_DIR_BIT];
        ca_space <= ca_full[CA_SPACE_BIT];
        ca_linear <= ca_full[CA_BURST_BIT];
        // Space bit does not enter the address: one flat space
        ca_half_page <= ca_full[CA_HP_HI:CA_HP_LO];
        ca_word <= ca_full[CA_WORD_HI:CA_WORD_LO];
      end
    end
  end

  // ------------------------------------------------------------
  // Latency counter
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n || dev_rst || state == DFH_IDLE) begin
      lat_cnt <= 5'h00;
    end else if (ca_done) begin
      lat_cnt <= lat_clocks;
    end else if (state == DFH_LAT && ck_rise && !lat_done) begin
      lat_cnt <= lat_cnt - 5'h01;
    end
  end

  // ------------------------------------------------------------
  // Write data: one word into the command buffer
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n || dev_rst) begin
      wr_hi <= 8'h00;
      cmd_wr <= 1'b0;
      cmd_half_page <= '0;
      cmd_word <= '0;
      cmd_data <= 16'h0000;
    end else begin
      cmd_wr <= 1'b0;
      if (state == DFH_WDATA && ck_rise) begin
        wr_hi <= dq_in;
      end
      // Second word and later ignored, burst bit not consulted
      if (state == DFH_WDATA && ck_fall && !cmd_wr && !busy) begin
        cmd_wr <= 1'b1;
        cmd_half_page <= ca_half_page;
        cmd_word <= ca_word;
        cmd_data <= {wr_hi, dq_in};
      end
    end
  end

  // Busy marks the word of this write as already taken
  always_ff @(posedge core_clk) begin
    if (!rst_n || dev_rst || state == DFH_IDLE) begin
      busy <= 1'b0;
    end else if (cmd_wr) begin
      busy <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Read data: strobe toggles with each data byte
  // ------------------------------------------------------------
  wire rd_active = (state == DFH_RDATA) && !dev_rst;
  always_ff @(posedge core_clk) begin
    if (!rst_n || dev_rst || !rd_active) begin
      rd_req <= 1'b0;
      rd_hold <= 16'h0000;
      rd_lo_phase <= 1'b0;
      rwds_out <= 1'b0;
      dq_out <= 8'h00;
    end else begin
      rd_req <= 1'b0;
      // A falling edge before the first rising one carries no byte
      if (strb_edge && (strb_rise || rd_lo_phase)) begin
        rwds_out <= strb_rise;
        rd_lo_phase <= strb_rise;
        if (strb_rise) begin
          rd_hold <= rd_data;
          dq_out <= rd_data[15:8];
          rd_req <= 1'b1;
        end else begin
          dq_out <= rd_hold[7:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || dev_rst) begin
      dq_oe <= 1'b0;
      rwds_oe <= 1'b0;
    end else begin
      dq_oe <= (next_state == DFH_RDATA);
      rwds_oe <= (next_state == DFH_RDATA);
    end
  end

  // ------------------------------------------------------------
  // Sideband outputs
  // ------------------------------------------------------------
  logic [POR_CNT_W-1:0] por_cnt;
  logic por_released;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      por_cnt <= '0;
      por_released <= 1'b0;
      por_out_n <= 1'b0;
      por_oe <= 1'b1;
      standby <= 1'b0;
      int_out <= 1'b0;
      int_oe <= 1'b0;
      in_reset <= 1'b1;
    end else begin
      int_out <= 1'b0;
      int_oe <= event_pending;
      in_reset <= dev_rst;
      if (por_busy) begin
        por_cnt <= '0;
        por_released <= 1'b0;
      end else if (!por_released) begin
        if (por_cnt >= por_timeout || por_cnt >= POR_WAIT) begin
          por_released <= 1'b1;
        end else begin
          por_cnt <= por_cnt + 1'b1;
        end
      end
      por_out_n <= 1'b0;
      por_oe <= !(por_released && !por_busy);
      standby <= por_released && !por_busy && !dev_rst &&
                 (next_state == DFH_IDLE);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_OE_ONLY_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
    dq_oe |-> $past(state) == DFH_RDATA || state == DFH_RDATA)
    else $error("data driven outside read phase");
  AST_RST_FLOAT: assert property (@(posedge core_clk) disable iff (!rst_n)
    dev_rst |=> !dq_oe && !rwds_oe)
    else $error("bus driven during hardware reset");
  AST_CS_ABORT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state != DFH_IDLE && cs_rise) |=> state == DFH_IDLE)
    else $error("select release did not end transaction");
  AST_START: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == DFH_IDLE && cs_fall && !ck_s && !dev_rst) |=> state == DFH_CA)
    else $error("select fall did not start transaction");
  AST_LAT_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ca_done && !dev_rst && lat_code == 4'h0) |=> lat_cnt == 5'h05)
    else $error("latency code zero not five clocks");
  AST_ONE_WORD: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_wr |=> !cmd_wr)
    else $error("second write word accepted");
  AST_DIR: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ca_done && !dev_rst) |=> ca_read == $past(ca_full[CA_DIR_BIT]))
    else $error("direction bit not decoded");
  AST_POR_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
    por_busy |=> por_oe && !por_out_n)
    else $error("reset output released during power-on reset");
  AST_INT: assert property (@(posedge core_clk) disable iff (!rst_n)
    event_pending |=> int_oe && !int_out)
    else $error("interrupt not pulled low");
endmodule : dfh_bus_if

// *** dfh_bus_if_tb_top.sv ***
// Purpose: Self-checking bench for the flash host bus interface
// Assumes: Host model makes the bus clock, core_clk is 100 MHz
// Notes: Expected results are queued and compared by a monitor
`timescale 1ns/1ps
module dfh_bus_if_tb_top;
  import dfh_pkg::*;
  logic core_clk, rst_n, cs_n_pin, bus_clk_pin, skew_clock, skew_clock_n;
  logic [7:0] dq_in, dq_out, host_dq, latency_config_reg;
  logic dq_oe, rwds_out, rwds_oe, hw_reset_n_pin, int_out, int_oe;
  logic por_out_n, por_oe, skew_clock_en, por_busy, event_pending, ev_d;
  logic [POR_CNT_W-1:0] por_timeout;
  logic ca_valid, ca_read, ca_space, ca_linear, cmd_wr, rd_req;
  logic [HP_W-1:0] ca_half_page, cmd_half_page;
  logic [WORD_W-1:0] ca_word, cmd_word;
  logic [15:0] cmd_data, rd_data;
  logic standby, in_reset, busy;
  logic [63:0] q_ca[$], q_cmd[$], q_rd[$];
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int tmo, n, k;
  logic [31:0] seed_v;
  logic [3:0] k_codes[5] = '{4'h0, 4'h3, 4'hb, 4'hc, 4'hf};

  assign dq_in = dq_oe ? dq_out : host_dq;

  dfh_bus_if #(.POR_WAIT(16'h0014)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin),
    .bus_clk_pin(bus_clk_pin), .skew_clock(skew_clock),
    .skew_clock_n(skew_clock_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .rwds_out(rwds_out), .rwds_oe(rwds_oe),
    .hw_reset_n_pin(hw_reset_n_pin), .int_out(int_out), .int_oe(int_oe),
    .por_out_n(por_out_n), .por_oe(por_oe),
    .latency_config_reg(latency_config_reg), .skew_clock_en(skew_clock_en),
    .por_timeout(por_timeout), .por_busy(por_busy),
    .event_pending(event_pending), .ca_valid(ca_valid), .ca_read(ca_read),
    .ca_space(ca_space), .ca_linear(ca_linear),
    .ca_half_page(ca_half_page), .ca_word(ca_word), .cmd_wr(cmd_wr),
    .cmd_half_page(cmd_half_page), .cmd_word(cmd_word),
    .cmd_data(cmd_data), .rd_data(rd_data), .rd_req(rd_req),
    .standby(standby), .in_reset(in_reset), .busy(busy));

  dfh_host_model host (
    .cs_n(cs_n_pin), .bus_clk(bus_clk_pin), .skew_clock(skew_clock),
    .skew_clock_n(skew_clock_n), .host_dq(host_dq), .rwds_out(rwds_out),
    .dq_out(dq_out));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // ------------------------------------------------------------
  // Monitor: pops the oldest note whenever a result shows
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    ev_d <= event_pending;
    if (rst_n) begin
      if (ca_valid === 1'b1) begin
        if (q_ca.size() == 0) check("ca_spurious", 64'h1, 64'h0);
        else check("ca_fields", 64'({ca_read, ca_space, ca_linear,
          ca_half_page, ca_word}), q_ca.pop_front());
      end
      if (cmd_wr === 1'b1) begin
        if (q_cmd.size() == 0) check("cmd_spurious", 64'h1, 64'h0);
        else check("cmd_fields", 64'({cmd_half_page, cmd_word, cmd_data}),
          q_cmd.pop_front());
      end
      if (host.got.size() > 0) begin
        if (q_rd.size() == 0) check("rd_spurious", 64'h1, 64'h0);
        else check("rd_word", 64'(host.got.pop_front()),
          q_rd.pop_front());
      end
      if (host.quiet) check("oe_idle", 64'({dq_oe, rwds_oe}), 64'h0);
      check("int_pin", 64'({int_oe, int_out}), 64'({ev_d, 1'b0}));
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    if (rd_req === 1'b1) begin
      rd_data <= rd_data + 16'h0001;
    end
    if (cyc == 20000) begin
      n_errors++;
      $display("timeout after %0d cycles", cyc);
      end_sim();
    end
  end

  task automatic run(input logic [3:0] code, input logic dir,
                     input logic sp, input int nw, input logic cut);
    logic [47:0] ca;
    logic [31:0] wd;
    logic [15:0] base;
    int lat;
    int i;
    ca = {dir, sp, 1'($urandom), 29'($urandom), 13'h0000, 3'($urandom)};
    wd = $urandom;
    base = 16'($urandom);
    lat = (code > 4'hb) ? 16 : int'(code) + 5;
    @(posedge core_clk);
    latency_config_reg <= {code, 4'($urandom)};
    rd_data <= base;
    event_pending <= 1'($urandom);
    if (!cut) q_ca.push_back(64'({ca[47:16], ca[2:0]}));
    if (!cut && !dir) q_cmd.push_back(64'({ca[44:16], ca[2:0], wd[31:16]}));
    for (i = 0; i < nw && dir && !cut; i++) begin
      q_rd.push_back(64'(base + 16'(i)));
    end
    host.xfer(ca, lat, dir ? nw + 3 : nw, dir ? nw : 0, wd, cut);
    if (dir && nw > 0) check("latency", 64'(host.first_rise - lat) >> 1,
      64'h0);
    repeat (4) @(posedge core_clk);
  endtask : run

  initial begin
    seed_v = $urandom(32'h0a41332e);
    tmo = 8 + int'($urandom % 20);
    rst_n = 1'b0;
    hw_reset_n_pin = 1'b1;
    latency_config_reg = 8'h00;
    skew_clock_en = 1'b0;
    por_timeout = 16'(tmo);
    por_busy = 1'b1;
    event_pending = 1'b0;
    rd_data = 16'h0000;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    check("por_held", 64'({por_oe, por_out_n, standby}), 64'h4);
    por_busy <= 1'b0;
    n = 0;
    while (por_oe === 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    check("por_time", 64'(n - (tmo < 20 ? tmo : 20)) >> 2, 64'h0);
    repeat (3) @(posedge core_clk);
    check("standby", 64'(standby), 64'h1);
    $display("test power_on done");
    foreach (k_codes[j]) begin
      skew_clock_en <= (k_codes[j] == 4'h3);
      run(k_codes[j], 1'b1, 1'($urandom), 1 + int'($urandom % 4), 1'b0);
    end
    skew_clock_en <= 1'b0;
    $display("test read_latency done");
    run(4'h0, 1'b0, 1'b0, 1, 1'b0);
    run(4'h0, 1'b0, 1'b1, 2, 1'b0);
    run(4'h0, 1'b0, 1'b0, 1, 1'b1);
    run(4'h0, 1'b0, 1'b0, 1, 1'b0);
    $display("test write_buffer done");
    fork
      run(4'h2, 1'b1, 1'b0, 0, 1'b0);
      begin
        wait (rwds_oe === 1'b1);
        @(posedge core_clk);
        hw_reset_n_pin <= 1'b0;
        repeat (8) @(posedge core_clk);
        check("hw_float", 64'({dq_oe, rwds_oe, in_reset}), 64'h1);
        hw_reset_n_pin <= 1'b1;
      end
    join
    run(4'h1, 1'b1, 1'b0, 2, 1'b0);
    $display("test hw_reset done");
    repeat (40) @(posedge core_clk);
    check("queues_empty", 64'(q_ca.size() + q_cmd.size() + q_rd.size()),
      64'h0);
    end_sim();
  end
endmodule : dfh_bus_if_tb_top

// *** dfh_host_model.sv ***
// Purpose: Host bus master model that frames transfers to the flash port
// Assumes: Bus clock is 160 ns and stands low outside frames
// Notes: Released data lines show an inverted, changing pattern
`timescale 1ns/1ps
module dfh_host_model (
  // Host driven pins
  output logic cs_n,
  output logic bus_clk,
  output logic skew_clock,
  output logic skew_clock_n,
  output logic [7:0] host_dq,
  // Device return
  input wire logic rwds_out,
  input wire logic [7:0] dq_out
);
  logic quiet;
  logic cap_en;
  logic skew_run;
  int rise_cnt;
  int first_rise;
  int ncap_r;
  logic [7:0] hi_b;
  logic [15:0] got[$];

  initial begin
    cs_n = 1'b1;
    bus_clk = 1'b0;
    skew_clock = 1'b0;
    skew_clock_n = 1'b0;
    host_dq = 8'h5a;
    quiet = 1'b1;
    cap_en = 1'b0;
    skew_run = 1'b0;
    rise_cnt = 0;
    first_rise = -1;
    ncap_r = 0;
  end

  // One bus clock edge, data set 20 ns before it and held 60 ns after
  task automatic hedge(input logic v, input logic [7:0] d);
    host_dq = d;
    #20;
    bus_clk = v;
    if (skew_run) begin
      skew_clock <= #20 v;
      skew_clock_n <= #20 ~v;
    end
    if (v) begin
      rise_cnt++;
    end
    #60;
  endtask : hedge

  task automatic xfer(input logic [47:0] ca, input int lat, input int nclk,
                      input int ncap, input logic [31:0] wd, input logic cut);
    int i;
    skew_run = ca[47];
    ncap_r = ncap;
    first_rise = -1;
    #25;
    cs_n = 1'b0;
    #50;
    for (i = 0; i < (cut ? 2 : 6); i++) begin
      hedge(~i[0], ca[47-8*i -: 8]);
    end
    rise_cnt = 0;
    if (!cut && ca[47]) begin
      for (i = 0; i < lat; i++) begin
        if (i == lat - 1) begin
          quiet = 1'b0;
          cap_en = 1'b1;
        end
        hedge(1'b1, ~host_dq);
        hedge(1'b0, ~host_dq);
      end
      cap_en = 1'b1;
      for (i = 0; i < nclk; i++) begin
        hedge(1'b1, ~host_dq);
        hedge(1'b0, ~host_dq);
      end
    end else if (!cut) begin
      for (i = 0; i < nclk; i++) begin
        hedge(1'b1, wd[31-16*i -: 8]);
        hedge(1'b0, wd[23-16*i -: 8]);
      end
    end
    cs_n = 1'b1;
    host_dq = ~host_dq;
    skew_run = 1'b0;
    #80;
    cap_en = 1'b0;
    quiet = 1'b1;
  endtask : xfer

  // Collect read words from strobe transitions
  always @(rwds_out) begin
    #1;
    if (cap_en && rwds_out === 1'b1) begin
      if (first_rise < 0) begin
        first_rise = rise_cnt;
      end
      hi_b = dq_out;
    end else if (cap_en && rwds_out === 1'b0 && ncap_r > 0) begin
      got.push_back({hi_b, dq_out});
      ncap_r--;
    end
  end
endmodule : dfh_host_model

// *** dfh_pkg.sv ***
// Purpose: Shared constants for the flash host bus interface
// Assumes: Device logic runs on core_clk at 100 MHz
// Notes: Bus clock and select are sampled, not used as clocks
package dfh_pkg;
  // ------------------------------------------------------------
  // Command/address field positions
  // ------------------------------------------------------------
  localparam int CA_W = 48;
  localparam int CA_DIR_BIT = 47;
  localparam int CA_SPACE_BIT = 46;
  localparam int CA_BURST_BIT = 45;
  localparam int CA_HP_HI = 44;
  localparam int CA_HP_LO = 16;
  localparam int CA_WORD_HI = 2;
  localparam int CA_WORD_LO = 0;
  localparam int HP_W = CA_HP_HI - CA_HP_LO + 1;
  localparam int WORD_W = CA_WORD_HI - CA_WORD_LO + 1;
  localparam int CA_EDGES = 6;
  // ------------------------------------------------------------
  // Latency configuration
  // ------------------------------------------------------------
  localparam int LAT_HI = 7;
  localparam int LAT_LO = 4;
  localparam logic [3:0] LAT_BASE = 4'h5;
  localparam logic [3:0] LAT_MAX_CODE = 4'hb;
  localparam logic [7:0] LAT_CFG_RESET = 8'hb0;
  // ------------------------------------------------------------
  // Power-on reset output timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int POR_US = 10;
  localparam int POR_CYCLES = POR_US * CLK_MHZ;
  localparam int POR_CNT_W = 16;
  localparam logic [POR_CNT_W-1:0] POR_TIMEOUT_RESET = 16'h0064;
  // ------------------------------------------------------------
  // Transaction states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    DFH_IDLE = 3'b000,
    DFH_CA = 3'b001,
    DFH_LAT = 3'b010,
    DFH_RDATA = 3'b011,
    DFH_WDATA = 3'b100,
    DFH_DONE = 3'b101
  } dfh_state_e;
endpackage : dfh_pkg

// *** dfh_sync.sv ***
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to core_clk
// Notes: Output changes once stages two and three agree
`timescale 1ns/1ps
module dfh_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Signals
  input wire logic async_in,
  output logic sync_out
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_out <= s3;
      end
    end
  end
endmodule : dfh_sync
